/* rtl/csfr_alu_flags.sv */
// Arithmetic unit: result and flag derivation
`timescale 1ns/10ps
module csfr_alu_flags #(
  parameter int WIDTH = 8
) (
  input wire csfr_pkg::csfr_op_type op,
  input wire logic [WIDTH-1:0] opA,
  input wire logic [WIDTH-1:0] opB,
  input wire logic carryIn,
  output logic [WIDTH-1:0] result,
  output logic zeroOut,
  output logic digitCarryOut,
  output logic carryOut,
  output logic affectsZ,
  output logic affectsCarry
);
  logic [WIDTH:0] sum;
  logic [4:0] nibSum;
  logic [WIDTH-1:0] addend;

  // Subtraction adds the two's complement of the second operand
  always_comb begin
    addend = (op == csfr_pkg::CSFR_OP_SUB) ? WIDTH'(~opB + 1'b1) : opB;
    sum = {1'b0, opA} + {1'b0, addend};
    nibSum = {1'b0, opA[3:0]} + {1'b0, addend[3:0]};
    result = opA;
    digitCarryOut = nibSum[4];
    carryOut = sum[WIDTH];
    affectsZ = 1'b0;
    affectsCarry = 1'b0;
    // A zero subtrahend gives carry out of the complement add, meaning no borrow
    if (op == csfr_pkg::CSFR_OP_SUB && opB == '0) begin
      digitCarryOut = 1'b1;
      carryOut = 1'b1;
    end
    case (op)
      csfr_pkg::CSFR_OP_ADD, csfr_pkg::CSFR_OP_SUB: begin
        result = sum[WIDTH-1:0];
        affectsZ = 1'b1;
        affectsCarry = 1'b1;
      end
      csfr_pkg::CSFR_OP_ROTR: begin
        result = {carryIn, opA[WIDTH-1:1]};
        carryOut = opA[0];
        affectsCarry = 1'b1;
      end
      csfr_pkg::CSFR_OP_ROTL: begin
        result = {opA[WIDTH-2:0], carryIn};
        carryOut = opA[WIDTH-1];
        affectsCarry = 1'b1;
      end
      csfr_pkg::CSFR_OP_LOGIC: begin
        result = opB;
        affectsZ = 1'b1;
      end
      default: begin
        result = opA;
      end
    endcase
    zeroOut = (result == '0);
  end
endmodule : csfr_alu_flags

/* rtl/csfr_pkg.sv */
// Package: processor status register constants and types
package csfr_pkg;
  // ==========================================================
  // Register addresses (9-bit data space)
  localparam logic [8:0] STATUS_ADDR_B0 = 9'h003;
  localparam logic [8:0] STATUS_ADDR_B1 = 9'h083;
  localparam logic [8:0] STATUS_ADDR_B2 = 9'h103;
  localparam logic [8:0] STATUS_ADDR_B3 = 9'h183;
  localparam logic [8:0] OPTION_ADDR_B1 = 9'h081;
  localparam logic [8:0] OPTION_ADDR_B3 = 9'h181;
  localparam logic [6:0] STATUS_LOW7 = 7'h03;
  // ==========================================================
  // Status and option bit positions
  localparam int BIT_IND_BANK = 7;
  localparam int BIT_RPH = 6;
  localparam int BIT_RPL = 5;
  localparam int BIT_TO = 4;
  localparam int BIT_PWRDN = 3;
  localparam int BIT_Z = 2;
  localparam int BIT_DC = 1;
  localparam int BIT_C = 0;
  localparam int BIT_PSA = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  // ==========================================================
  // Arithmetic operations
  typedef enum logic [2:0] {
    CSFR_OP_NONE = 3'h0,
    CSFR_OP_ADD = 3'h1,
    CSFR_OP_SUB = 3'h2,
    CSFR_OP_ROTR = 3'h3,
    CSFR_OP_ROTL = 3'h4,
    CSFR_OP_LOGIC = 3'h5
  } csfr_op_type;
endpackage : csfr_pkg

/* rtl/csfr_status_regs.sv */
// Processor status and option registers with flag update logic
// Operation
// - Indirect bank bit selects upper or lower half
// - Direct bank field selects one of four banks
// - Timeout flag set by powerup, clear, sleep
// - Digit carry from bit 3 on add/sub
// - Carry from top bit on add/sub
// - Subtract flags mean inverted borrow, but digit carry is 0 for a nonzero subtrahend whose low nibble is 0
// - Subtract adds second operand's two's complement
// - Rotates load carry with shifted-out bit
// - Status mirrored at four bank addresses
// - Option register fully readable and writable
// - Prescaler to watchdog gives timer 1:1
// - Timeout and powerdown flags ignore writes
// - Flag results override writes to status
`timescale 1ns/10ps
module csfr_status_regs #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [8:0] regAddr,
  input wire logic regWrEn,
  input wire logic [WIDTH-1:0] regWrData,
  output logic [WIDTH-1:0] regRdData,
  input wire csfr_pkg::csfr_op_type aluOp,
  input wire logic aluExec,
  input wire logic [WIDTH-1:0] aluOpA,
  input wire logic [WIDTH-1:0] aluOpB,
  output logic [WIDTH-1:0] aluResult,
  input wire logic watchdogClearInstr,
  input wire logic sleepInstr,
  input wire logic watchdogTimeout,
  input wire logic [6:0] directLowAddr,
  input wire logic [7:0] indirectLowAddr,
  output logic [8:0] directAddr,
  output logic [8:0] indirectAddr,
  output logic [7:0] optionBits,
  output logic timerPrescaleBypass
);
  // ==========================================================
  // Register state
  logic [7:0] status_ff;
  logic [7:0] option_ff;
  logic [7:0] nxt_status;
  logic [WIDTH-1:0] aluRes;
  logic aluZ;
  logic aluDc;
  logic aluC;
  logic aluAffZ;
  logic aluAffC;
  logic statusHit;
  logic optionHit;

  csfr_alu_flags #(.WIDTH(WIDTH)) uAlu (
    .op(aluOp),
    .opA(aluOpA),
    .opB(aluOpB),
    .carryIn(status_ff[csfr_pkg::BIT_C]),
    .result(aluRes),
    .zeroOut(aluZ),
    .digitCarryOut(aluDc),
    .carryOut(aluC),
    .affectsZ(aluAffZ),
    .affectsCarry(aluAffC)
  );

  // ==========================================================
  // Address decode: status ignores bank bits so all its mirrors hit one register; option decodes banks 1 and 3 only
  assign statusHit = (regAddr[6:0] == csfr_pkg::STATUS_LOW7);
  assign optionHit = (regAddr == csfr_pkg::OPTION_ADDR_B1) ||
                     (regAddr == csfr_pkg::OPTION_ADDR_B3);

  // Next status: write first, then hardware flags take priority
  always_comb begin
    nxt_status = status_ff;
    if (regWrEn && statusHit) begin
      nxt_status[csfr_pkg::BIT_IND_BANK] = regWrData[csfr_pkg::BIT_IND_BANK];
      nxt_status[csfr_pkg::BIT_RPH] = regWrData[csfr_pkg::BIT_RPH];
      nxt_status[csfr_pkg::BIT_RPL] = regWrData[csfr_pkg::BIT_RPL];
      // Timeout and powerdown bits are not writable
      if (!(aluExec && aluAffZ)) begin
        nxt_status[csfr_pkg::BIT_Z] = regWrData[csfr_pkg::BIT_Z];
      end
      if (!(aluExec && aluAffC)) begin
        nxt_status[csfr_pkg::BIT_C] = regWrData[csfr_pkg::BIT_C];
      end
      if (!(aluExec && aluAffC && aluAffZ)) begin
        nxt_status[csfr_pkg::BIT_DC] = regWrData[csfr_pkg::BIT_DC];
      end
    end
    if (aluExec && aluAffZ) begin
      nxt_status[csfr_pkg::BIT_Z] = aluZ;
    end
    if (aluExec && aluAffC) begin
      nxt_status[csfr_pkg::BIT_C] = aluC;
    end
    if (aluExec && aluAffC && aluAffZ) begin
      nxt_status[csfr_pkg::BIT_DC] = aluDc;
    end
    // Event flags: timeout wins over a same-cycle clear instruction
    if (watchdogClearInstr) begin
      nxt_status[csfr_pkg::BIT_TO] = 1'b1;
      nxt_status[csfr_pkg::BIT_PWRDN] = 1'b1;
    end
    if (sleepInstr) begin
      nxt_status[csfr_pkg::BIT_TO] = 1'b1;
      nxt_status[csfr_pkg::BIT_PWRDN] = 1'b0;
    end
    if (watchdogTimeout) begin
      nxt_status[csfr_pkg::BIT_TO] = 1'b0;
    end
  end

  // ==========================================================
  // Status register; reset models power-up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      status_ff <= csfr_pkg::STATUS_RESET;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Option register, plain read/write
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      option_ff <= csfr_pkg::OPTION_RESET;
    end else if (regWrEn && optionHit) begin
      option_ff <= regWrData;
    end
  end

  // ==========================================================
  // Registered outputs: read mux, bank addresses, option controls
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      regRdData <= '0;
      aluResult <= '0;
      directAddr <= '0;
      indirectAddr <= '0;
      optionBits <= csfr_pkg::OPTION_RESET;
      timerPrescaleBypass <= 1'b1;
    end else begin
      regRdData <= statusHit ? nxt_status : (optionHit ? option_ff : '0);
      aluResult <= aluRes;
      // Bank 0-3 from the direct field
      directAddr <= {nxt_status[csfr_pkg::BIT_RPH:csfr_pkg::BIT_RPL], directLowAddr};
      // Upper or lower half for indirect access
      indirectAddr <= {nxt_status[csfr_pkg::BIT_IND_BANK], indirectLowAddr};
      optionBits <= option_ff;
      // Prescaler on the watchdog leaves the timer undivided
      timerPrescaleBypass <= option_ff[csfr_pkg::BIT_PSA];
    end
  end

  // ==========================================================
  // Checks
  a_mirror_read: assert property (@(posedge ref_clk) disable iff (rst)
    (regAddr == csfr_pkg::STATUS_ADDR_B2) |=> (regRdData == status_ff))
    else $error("status mirror read mismatch");
  a_sleep_flags: assert property (@(posedge ref_clk) disable iff (rst)
    (sleepInstr && !watchdogTimeout) |=>
      (status_ff[csfr_pkg::BIT_TO] && !status_ff[csfr_pkg::BIT_PWRDN]))
    else $error("sleep flags wrong");
  a_clear_flags: assert property (@(posedge ref_clk) disable iff (rst)
    (watchdogClearInstr && !sleepInstr && !watchdogTimeout) |=>
      (status_ff[csfr_pkg::BIT_TO] && status_ff[csfr_pkg::BIT_PWRDN]))
    else $error("watchdog clear flags wrong");
  a_timeout_flag: assert property (@(posedge ref_clk) disable iff (rst)
    watchdogTimeout |=> !status_ff[csfr_pkg::BIT_TO])
    else $error("timeout flag not cleared");
  a_event_write: assert property (@(posedge ref_clk) disable iff (rst)
    (!watchdogClearInstr && !sleepInstr && !watchdogTimeout) |=>
      $stable(status_ff[csfr_pkg::BIT_TO:csfr_pkg::BIT_PWRDN]))
    else $error("event flags changed by write");
  a_flag_override: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && aluAffZ && regWrEn && statusHit) |=>
      (status_ff[csfr_pkg::BIT_Z] == $past(aluZ)))
    else $error("status write not suppressed");
  a_rotate_right: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && aluOp == csfr_pkg::CSFR_OP_ROTR) |=>
      (status_ff[csfr_pkg::BIT_C] == $past(aluOpA[0])))
    else $error("rotate carry wrong");
  a_rotate_left: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && aluOp == csfr_pkg::CSFR_OP_ROTL) |=>
      (status_ff[csfr_pkg::BIT_C] == $past(aluOpA[WIDTH-1])))
    else $error("rotate left carry wrong");
  a_add_carry: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && aluOp == csfr_pkg::CSFR_OP_ADD) |=>
      (status_ff[csfr_pkg::BIT_C] == $past(({1'b0, aluOpA} + {1'b0, aluOpB}) > 9'h0ff)))
    else $error("add carry wrong");
  a_add_digit: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && aluOp == csfr_pkg::CSFR_OP_ADD) |=>
      (status_ff[csfr_pkg::BIT_DC] ==
       $past(({1'b0, aluOpA[3:0]} + {1'b0, aluOpB[3:0]}) > 5'h0f)))
    else $error("add digit carry wrong");
  a_sub_borrow: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && aluOp == csfr_pkg::CSFR_OP_SUB) |=>
      (status_ff[csfr_pkg::BIT_C] == $past(aluOpA >= aluOpB) &&
       status_ff[csfr_pkg::BIT_DC] == $past(aluOpA[3:0] >= aluOpB[3:0])))
    else $error("subtract borrow wrong");
  // Zero flag and registered result leave on the same edge, so they must agree
  a_zero_flag: assert property (@(posedge ref_clk) disable iff (rst)
    (aluExec && (aluOp == csfr_pkg::CSFR_OP_ADD || aluOp == csfr_pkg::CSFR_OP_SUB)) |=>
      (status_ff[csfr_pkg::BIT_Z] == (aluResult == '0)))
    else $error("zero flag wrong");
  // Bank outputs follow the status value loaded on the same edge
  a_direct_bank: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |->
      (directAddr == {status_ff[csfr_pkg::BIT_RPH:csfr_pkg::BIT_RPL],
                      $past(directLowAddr)}))
    else $error("direct bank address wrong");
  a_indirect_bank: assert property (@(posedge ref_clk) disable iff (rst)
    !$past(rst) |->
      (indirectAddr == {status_ff[csfr_pkg::BIT_IND_BANK], $past(indirectLowAddr)}))
    else $error("indirect bank address wrong");
  a_option_rw: assert property (@(posedge ref_clk) disable iff (rst)
    (regWrEn && regAddr == csfr_pkg::OPTION_ADDR_B3) |=> ##1 (optionBits == $past(regWrData, 2)))
    else $error("option write lost");
endmodule : csfr_status_regs

/* sim/cpu_status_flags_register_test.sv */
// Self-checking bench for the processor status register block
`timescale 1ns/10ps
module cpu_status_flags_register_test;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [8:0] regAddr = 9'h003;
  logic regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] regRdData, aluResult, optionBits, aluOpA, aluOpB;
  csfr_pkg::csfr_op_type aluOp;
  logic aluExec, timerPrescaleBypass;
  logic wdClr = 1'b0, sleepIns = 1'b0, wdTmo = 1'b0;
  logic [8:0] directAddr, indirectAddr;
  logic [7:0] expStatus = 8'h18;
  int mismatches = 0;
  int check_count = 0;

  // ==========================================================
  // Clock and instances
  always #2.5 ref_clk = ~ref_clk;

  csfr_status_regs #(.WIDTH(8)) dut_u (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData), .aluOp(aluOp),
    .aluExec(aluExec), .aluOpA(aluOpA), .aluOpB(aluOpB), .aluResult(aluResult),
    .watchdogClearInstr(wdClr), .sleepInstr(sleepIns), .watchdogTimeout(wdTmo),
    .directLowAddr(7'h25), .indirectLowAddr(8'h9a), .directAddr(directAddr),
    .indirectAddr(indirectAddr), .optionBits(optionBits),
    .timerPrescaleBypass(timerPrescaleBypass));

  csfr_core_model core_u (.ref_clk(ref_clk), .aluOp(aluOp), .aluExec(aluExec),
    .aluOpA(aluOpA), .aluOpB(aluOpB));

  // ==========================================================
  // Access and compare tasks, all entered at a falling edge
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge ref_clk);
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    regAddr = a;
    @(negedge ref_clk);
    check("read data", {1'b0, e}, {1'b0, regRdData});
  endtask : rd

  // Flags worked out as an add of the inverted operand plus one for subtract
  task automatic alu(input csfr_pkg::csfr_op_type op, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    logic sub;
    sub = (op == csfr_pkg::CSFR_OP_SUB);
    s = {1'b0, a} + {1'b0, sub ? ~b : b} + {8'h00, sub};
    n = {1'b0, a[3:0]} + {1'b0, sub ? ~b[3:0] : b[3:0]} + {4'h0, sub};
    regAddr = 9'h003;
    core_u.issue(op, a, b);
    case (op)
      csfr_pkg::CSFR_OP_ROTR: expStatus[0] = a[0];
      csfr_pkg::CSFR_OP_ROTL: expStatus[0] = a[7];
      csfr_pkg::CSFR_OP_LOGIC: expStatus[2] = (b == 8'h00);
      default: begin
        expStatus[2:0] = {s[7:0] == 8'h00, n[4], s[8]};
        check("alu result", {1'b0, s[7:0]}, {1'b0, aluResult});
      end
    endcase
    check("status", {1'b0, expStatus}, {1'b0, regRdData});
    // Idle cycle so a following issue never re-raises the strobe in this step
    @(negedge ref_clk);
  endtask : alu

  // Event pulse {timeout, sleep, clear}, then expected timeout and powerdown bits
  task automatic ev(input logic [2:0] k, input logic [1:0] toPd);
    {wdTmo, sleepIns, wdClr} = k;
    @(negedge ref_clk);
    {wdTmo, sleepIns, wdClr} = 3'h0;
    expStatus[4:3] = toPd;
    rd(9'h003, expStatus);
  endtask : ev

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Hang guard: the whole run needs far fewer cycles than this
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    rd(9'h003, 8'h18);
    rd(9'h181, 8'hff);
    $display("test reset done");
    // Write through one mirror, read through the next; timeout and powerdown written 0
    for (int i = 0; i < 8; i++) begin
      wr({i[1:0], 7'h03}, {i[2:0], 2'b00, i[2:0]});
      expStatus = {i[2:0], expStatus[4:3], i[2:0]};
      check("direct address", {i[1:0], 7'h25}, directAddr);
      check("indirect address", {i[2], 8'h9a}, indirectAddr);
      rd({i[1:0] + 2'h1, 7'h03}, expStatus);
    end
    $display("test banks done");
    alu(csfr_pkg::CSFR_OP_ADD, 8'h0f, 8'h01);
    alu(csfr_pkg::CSFR_OP_ADD, 8'hf0, 8'h10);
    alu(csfr_pkg::CSFR_OP_SUB, 8'h05, 8'h03);
    alu(csfr_pkg::CSFR_OP_SUB, 8'h03, 8'h05);
    alu(csfr_pkg::CSFR_OP_SUB, 8'h10, 8'h01);
    alu(csfr_pkg::CSFR_OP_SUB, 8'h07, 8'h00);
    alu(csfr_pkg::CSFR_OP_ROTR, 8'h01, 8'h01);
    alu(csfr_pkg::CSFR_OP_ROTR, 8'h02, 8'h02);
    alu(csfr_pkg::CSFR_OP_ROTL, 8'h80, 8'h80);
    alu(csfr_pkg::CSFR_OP_ROTL, 8'h7f, 8'h7f);
    alu(csfr_pkg::CSFR_OP_LOGIC, 8'h00, 8'h00);
    alu(csfr_pkg::CSFR_OP_LOGIC, 8'h00, 8'h3c);
    // Write to status in the same cycle as an add: bank bits taken, flags from the add
    fork
      core_u.issue(csfr_pkg::CSFR_OP_ADD, 8'h80, 8'h80);
      wr(9'h083, 8'h47);
    join
    expStatus = {3'b010, expStatus[4:3], 3'b101};
    rd(9'h003, expStatus);
    $display("test flags done");
    ev(3'h4, 2'b01);
    ev(3'h1, 2'b11);
    ev(3'h2, 2'b10);
    ev(3'h5, 2'b01);
    ev(3'h1, 2'b11);
    $display("test events done");
    wr(9'h081, 8'h00);
    rd(9'h181, 8'h00);
    check("bypass", 9'h000, {8'h00, timerPrescaleBypass});
    wr(9'h181, 8'ha8);
    rd(9'h081, 8'ha8);
    check("option bits", 9'h0a8, {1'b0, optionBits});
    check("bypass", 9'h001, {8'h00, timerPrescaleBypass});
    wr(9'h010, 8'h55);
    rd(9'h010, 8'h00);
    rd(9'h003, expStatus);
    $display("test option done");
    print_verdict();
  end
endmodule : cpu_status_flags_register_test

/* sim/csfr_core_model.sv */
// Core-side model that issues arithmetic instructions to the status block
`timescale 1ns/10ps
module csfr_core_model (
  input wire logic ref_clk,
  output csfr_pkg::csfr_op_type aluOp,
  output logic aluExec,
  output logic [7:0] aluOpA,
  output logic [7:0] aluOpB
);
  // ==========================================================
  // Idle instruction bus at time zero
  initial begin
    aluOp = csfr_pkg::CSFR_OP_NONE;
    aluExec = 1'b0;
    aluOpA = 8'h00;
    aluOpB = 8'h00;
  end

  // One-cycle instruction, called at a falling edge; operands are inverted
  // once idle so that stale values cannot pass for fresh ones
  task automatic issue(input csfr_pkg::csfr_op_type op, input logic [7:0] a, input logic [7:0] b);
    aluOp = op;
    aluOpA = a;
    aluOpB = b;
    aluExec = 1'b1;
    @(negedge ref_clk);
    aluExec = 1'b0;
    aluOp = csfr_pkg::CSFR_OP_NONE;
    aluOpA = ~a;
    aluOpB = ~b;
  endtask : issue
endmodule : csfr_core_model
